// File: logic/otpc_defines.vh
// Constants for the one-time programmable ROM programming controller.
// Notes on behaviour
// RQ1 - Array is 8192 bytes, 13-bit address, 8-bit three-state data bus.
// RQ2 - Blank cells read as all ones until programmed.
// RQ3 - Programming only clears bits; written ones leave cells unchanged.
// RQ4 - Program: raise supplies, select low, enable high, pulse strobe low.
// RQ5 - Verify: supplies kept, select low, output enable low, strobe high.
// RQ6 - Normal read drives data only with select and enable low, strobe high.
// RQ7 - Standard initial pulse 1.0 ms, within 0.95 to 1.05 ms, core 6 V.
// RQ8 - High-speed initial pulse 100 us, within 95 to 105 us, core 6.25 V.
// RQ9 - Overprogram pulse width lies between 2.85 ms and 78.75 ms.
// RQ10 - Repeat pulses until verify matches, overprogram, fail past limit.
`ifndef OTPC_DEFINES_VH
`define OTPC_DEFINES_VH
`define OTPC_ADDR_W        13
`define OTPC_DATA_W        8
`define OTPC_BLANK         8'hFF
`define OTPC_CLK_MHZ       25
// Pulse widths in whole microseconds and derived cycles.
`define OTPC_STD_PW_US     1000
`define OTPC_HS_PW_US      100
`define OTPC_STD_CYC       (`OTPC_STD_PW_US * `OTPC_CLK_MHZ)
`define OTPC_HS_CYC        (`OTPC_HS_PW_US * `OTPC_CLK_MHZ)
// Overprogram is 3x the standard width per initial pulse, kept inside 2.85..78.75 ms.
`define OTPC_OVP_MULT      3
`define OTPC_OVP_MIN_US    2850
`define OTPC_OVP_MAX_US    78750
// Setup and hold times of 2 us, and a read access allowance of 1 us.
`define OTPC_SETUP_US      2
`define OTPC_SETUP_CYC     (`OTPC_SETUP_US * `OTPC_CLK_MHZ)
`define OTPC_ACC_CYC       25
`define OTPC_RETRY_MAX     25
`define OTPC_CNT_W         22
`endif

// File: logic/otpc_ctrl.v
// Host-side programmer and reader for an 8K x 8 one-time programmable ROM.
`timescale 1ns/1ns
`default_nettype none
`include "otpc_defines.vh"
module otpc_ctrl #(
   parameter [21:0] STD_CYC = `OTPC_STD_CYC,
   parameter [21:0] HS_CYC  = `OTPC_HS_CYC
) (
   // Clock and reset
   input  wire                     clk,
   input  wire                     rst_n,
   // User request port
   input  wire                     req_valid,
   input  wire                     req_prog,
   input  wire                     req_fast,
   input  wire [`OTPC_ADDR_W-1:0]  req_addr,
   input  wire [`OTPC_DATA_W-1:0]  req_data,
   output reg                      busy_q,
   output reg                      done_q,
   output reg                      fail_q,
   output reg  [`OTPC_DATA_W-1:0]  rdata_q,
   output reg  [5:0]               tries_q,
   // Device pins
   output reg  [`OTPC_ADDR_W-1:0]  rom_addr_q,
   input  wire [`OTPC_DATA_W-1:0]  rom_data_in,
   output reg  [`OTPC_DATA_W-1:0]  rom_data_out_q,
   output reg                      rom_data_oe_q,
   output reg                      chip_sel_n_q,
   output reg                      out_en_n_q,
   output reg                      program_strobe_n_q,
   output reg                      vpp_high_q,
   output reg                      vcc_prog_q,
   output reg                      vcc_fast_q
);
   // One sequencer serves both operations; program and read share the end
   // state, which drops every supply and strobe together.
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_SETUP = 3'h1;
   localparam [2:0] S_PULSE = 3'h2;
   localparam [2:0] S_HOLD  = 3'h3;
   localparam [2:0] S_VER   = 3'h4;
   localparam [2:0] S_OVP   = 3'h5;
   localparam [2:0] S_READ  = 3'h6;
   localparam [2:0] S_END   = 3'h7;

   reg                     rst_m_q;
   reg                     rst_s_q;
   reg  [`OTPC_DATA_W-1:0] din_m_q;
   reg  [`OTPC_DATA_W-1:0] din_s_q;
   reg  [2:0]              state_q;
   reg  [`OTPC_CNT_W-1:0]  cnt_q;
   reg                     ovp_q;
   reg                     fast_q;
   wire [`OTPC_CNT_W-1:0]  pw_cyc;
   wire [`OTPC_CNT_W-1:0]  ovp_cyc;
   wire [`OTPC_DATA_W-1:0] want;
   wire [31:0]             ovp_full;

   // Reset is released through two flip-flops.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end

   // Device data pins come from outside the clock domain.
   // The first stage may go metastable, so only the second one is read.
   always @(posedge clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         din_m_q <= `OTPC_BLANK;
         din_s_q <= `OTPC_BLANK;
      end else begin
         din_m_q <= rom_data_in;
         din_s_q <= din_m_q;
      end
   end

   assign pw_cyc = fast_q ? HS_CYC : STD_CYC; // [RQ7] [RQ8]
   // Overprogram is three standard widths per initial pulse in both modes,
   // so 1 to 25 initial pulses stay inside the legal overprogram window.
   // By the time it runs, tries_q already counts the overprogram itself.
   assign ovp_full = STD_CYC * (tries_q - 6'h01) * `OTPC_OVP_MULT; // [RQ9]
   assign ovp_cyc  = ovp_full[`OTPC_CNT_W-1:0];
   // Verify wants the whole byte back; a cell already cleared where the
   // request holds a one can never match, and that ends in a failure.
   assign want = rom_data_out_q; // [RQ3]

   always @(posedge clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         state_q            <= S_IDLE;
         cnt_q              <= {`OTPC_CNT_W{1'b0}};
         ovp_q              <= 1'b0;
         fast_q             <= 1'b0;
         busy_q             <= 1'b0;
         done_q             <= 1'b0;
         fail_q             <= 1'b0;
         rdata_q            <= `OTPC_BLANK;
         tries_q            <= 6'h00;
         rom_addr_q         <= {`OTPC_ADDR_W{1'b0}};
         rom_data_out_q     <= `OTPC_BLANK;
         rom_data_oe_q      <= 1'b0;
         chip_sel_n_q       <= 1'b1;
         out_en_n_q         <= 1'b1;
         program_strobe_n_q <= 1'b1;
         vpp_high_q         <= 1'b0;
         vcc_prog_q         <= 1'b0;
         vcc_fast_q         <= 1'b0;
      end else begin
         done_q <= 1'b0;
         cnt_q  <= cnt_q + 1'b1;
         case (state_q)
            S_IDLE: begin
               // A request is taken only here; one that comes while busy is lost.
               cnt_q <= {`OTPC_CNT_W{1'b0}};
               if (req_valid) begin
                  busy_q         <= 1'b1;
                  fail_q         <= 1'b0;
                  tries_q        <= 6'h00;
                  ovp_q          <= 1'b0;
                  fast_q         <= req_fast;
                  rom_addr_q     <= req_addr; // [RQ1]
                  rom_data_out_q <= req_data;
                  chip_sel_n_q   <= 1'b0;
                  if (req_prog) begin
                     // Supplies settle before data and strobe move.
                     vpp_high_q <= 1'b1; // [RQ4]
                     vcc_prog_q <= 1'b1;
                     vcc_fast_q <= req_fast;
                     state_q    <= S_SETUP;
                  end else begin
                     out_en_n_q <= 1'b0; // [RQ6]
                     state_q    <= S_READ;
                  end
               end
            end
            S_SETUP: begin
               // Each try starts here, so address, data and both supplies get
               // the full setup time again before the strobe falls.
               out_en_n_q    <= 1'b1;
               rom_data_oe_q <= 1'b1;
               if (cnt_q >= `OTPC_SETUP_CYC) begin
                  cnt_q              <= {`OTPC_CNT_W{1'b0}};
                  program_strobe_n_q <= 1'b0; // [RQ4]
                  tries_q            <= tries_q + 6'h01;
                  state_q            <= S_PULSE;
               end
            end
            S_PULSE: begin
               // The strobe stays low for exactly the selected width.
               if (cnt_q >= (ovp_q ? ovp_cyc : pw_cyc) - 1'b1) begin
                  cnt_q              <= {`OTPC_CNT_W{1'b0}};
                  program_strobe_n_q <= 1'b1;
                  state_q            <= S_HOLD;
               end
            end
            S_HOLD: begin
               // Data held 2 us past the strobe before the bus turns round.
               if (cnt_q >= `OTPC_SETUP_CYC) begin
                  cnt_q         <= {`OTPC_CNT_W{1'b0}};
                  rom_data_oe_q <= 1'b0;
                  out_en_n_q    <= 1'b0; // [RQ5]
                  state_q       <= S_VER;
               end
            end
            S_VER: begin
               // The synchroniser adds two cycles, well inside the access wait.
               if (cnt_q >= `OTPC_ACC_CYC) begin
                  cnt_q   <= {`OTPC_CNT_W{1'b0}};
                  rdata_q <= din_s_q;
                  if (ovp_q) begin
                     // A byte that moved after the match is a failure.
                     fail_q  <= (din_s_q != want); // [RQ10]
                     state_q <= S_END;
                  end else if (din_s_q == want) begin
                     ovp_q   <= 1'b1; // [RQ10]
                     state_q <= S_OVP;
                  end else if (tries_q >= `OTPC_RETRY_MAX) begin
                     fail_q  <= 1'b1; // [RQ10]
                     state_q <= S_END;
                  end else begin
                     state_q <= S_SETUP;
                  end
               end
            end
            S_OVP: begin
               // Overprogram runs at the standard core level.
               vcc_fast_q <= 1'b0;
               state_q    <= S_SETUP;
               cnt_q      <= {`OTPC_CNT_W{1'b0}};
            end
            S_READ: begin
               // Read mode keeps the strobe high and both supplies low.
               if (cnt_q >= `OTPC_ACC_CYC) begin
                  rdata_q <= din_s_q; // [RQ2]
                  state_q <= S_END;
               end
            end
            S_END: begin
               // The strobe is already high, so dropping the supplies here
               // cannot disturb a cell on the way out.
               chip_sel_n_q       <= 1'b1; // [RQ6]
               out_en_n_q         <= 1'b1;
               program_strobe_n_q <= 1'b1;
               rom_data_oe_q      <= 1'b0;
               vpp_high_q         <= 1'b0;
               vcc_prog_q         <= 1'b0;
               vcc_fast_q         <= 1'b0;
               busy_q             <= 1'b0;
               done_q             <= 1'b1;
               state_q            <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: testbench/otpc_rom_model.sv
// Behavioural model of the 8K x 8 one-time programmable ROM.
`timescale 1ns/1ns
`default_nettype none
module otpc_rom_model (
   // Device pins
   input  wire logic [12:0] addr,
   input  wire logic [7:0]  din,
   input  wire logic        cs_n,
   input  wire logic        oe_n,
   input  wire logic        program_strobe_n,
   input  wire logic        vpp,
   input  wire logic        vcc_prog,
   // Number of pulses that a location ignores before it takes a pulse.
   input  wire logic [2:0]  extra,
   output var  logic [7:0]  dout
);
   logic [7:0] mem [0:8191];
   logic [7:0] last_q;
   int         skip;
   wire        rd = !cs_n && !oe_n && program_strobe_n;
   initial begin
      for (int i = 0; i < 8192; i++)
         mem[i] = 8'hff;
      last_q = 8'h00;
      skip = 0;
   end
   // Slow cells make the programmer retry, as a marginal part would.
   always @(negedge program_strobe_n) begin
      if (!cs_n && oe_n && vpp && vcc_prog) begin
         if (skip < extra)
            skip++;
         else
            mem[addr] = mem[addr] & din;
      end
   end
   always @(posedge cs_n)
      skip = 0;
   always @* begin
      if (rd)
         last_q = mem[addr];
   end
   // A floating bus shows the inverse of the last byte, never a held value.
   assign dout = rd ? mem[addr] : ~last_q;
endmodule
`default_nettype wire

// File: testbench/otpc_ctrl_chk.sv
// Pin protocol checker for the ROM programming controller.
`timescale 1ns/1ns
`default_nettype none
module otpc_ctrl_chk #(
   parameter [21:0] STD_CYC = 22'h00_0014,
   parameter [21:0] HS_CYC  = 22'h00_0004
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       done_q,
   input wire logic [5:0] tries_q,
   input wire logic       rom_data_oe_q,
   input wire logic       chip_sel_n_q,
   input wire logic       out_en_n_q,
   input wire logic       program_strobe_n_q,
   input wire logic       vpp_high_q,
   input wire logic       vcc_prog_q,
   input wire logic       vcc_fast_q
);
   logic [21:0] low_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         low_q <= 22'h00_0000;
      else if (!program_strobe_n_q)
         low_q <= low_q + 22'h00_0001;
      else
         low_q <= 22'h00_0000;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   prog_entry_a: assert property ($fell(program_strobe_n_q) |->
      vpp_high_q && vcc_prog_q && $past(vpp_high_q, 20))
      else $error("strobe fell before supplies settled");
   pulse_pins_a: assert property (!program_strobe_n_q |->
      !chip_sel_n_q && out_en_n_q && rom_data_oe_q && vpp_high_q)
      else $error("pins wrong during program pulse");
   verify_pins_a: assert property (!out_en_n_q |->
      program_strobe_n_q && !rom_data_oe_q && !chip_sel_n_q)
      else $error("pins wrong during read or verify");
   std_width_a: assert property ($rose(program_strobe_n_q) &&
      !vcc_fast_q |-> low_q != 0 && low_q % STD_CYC == 0 &&
      low_q <= 75 * STD_CYC) else $error("standard pulse width wrong");
   fast_width_a: assert property ($rose(program_strobe_n_q) &&
      vcc_fast_q |-> low_q != 0 && low_q % HS_CYC == 0 &&
      low_q <= 75 * HS_CYC) else $error("fast pulse width wrong");
   fast_supply_a: assert property (vcc_fast_q &&
      !program_strobe_n_q |-> vcc_prog_q) else $error("fast supply alone");
   retry_cap_a: assert property (done_q |-> tries_q <= 6'h1a)
      else $error("too many pulses");
endmodule
bind otpc_ctrl otpc_ctrl_chk #(.STD_CYC(STD_CYC), .HS_CYC(HS_CYC)) u_chk (
   .clk(clk), .rst_n(rst_n), .done_q(done_q), .tries_q(tries_q),
   .rom_data_oe_q(rom_data_oe_q), .chip_sel_n_q(chip_sel_n_q),
   .out_en_n_q(out_en_n_q), .program_strobe_n_q(program_strobe_n_q),
   .vpp_high_q(vpp_high_q), .vcc_prog_q(vcc_prog_q),
   .vcc_fast_q(vcc_fast_q));
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the ROM programming controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_prog = 1'b0;
   logic        req_fast = 1'b0;
   logic [12:0] req_addr = 13'h0000;
   logic [7:0]  req_data = 8'h00, exp_b;
   logic [2:0]  extra = 3'h0;
   wire  logic  busy_q, done_q, fail_q, rom_data_oe_q, chip_sel_n_q;
   wire  logic  out_en_n_q, program_strobe_n_q, vpp_high_q, vcc_prog_q;
   wire  logic  vcc_fast_q;
   wire  logic [7:0]  rdata_q, rom_data_out_q, mdl_out, bus;
   wire  logic [5:0]  tries_q;
   wire  logic [12:0] rom_addr_q;
   int          fail_count = 0, tests_run = 0, cyc = 0, seed, i;
   int          ref_mem [int];
   int          used [$];
   always #20 clk = ~clk;
   assign bus = rom_data_oe_q ? rom_data_out_q : mdl_out;
   otpc_ctrl #(.STD_CYC(22'h00_0014), .HS_CYC(22'h00_0004)) dut (
      .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_prog(req_prog),
      .req_fast(req_fast), .req_addr(req_addr), .req_data(req_data),
      .busy_q(busy_q), .done_q(done_q), .fail_q(fail_q), .rdata_q(rdata_q),
      .tries_q(tries_q), .rom_addr_q(rom_addr_q), .rom_data_in(bus),
      .rom_data_out_q(rom_data_out_q), .rom_data_oe_q(rom_data_oe_q),
      .chip_sel_n_q(chip_sel_n_q), .out_en_n_q(out_en_n_q),
      .program_strobe_n_q(program_strobe_n_q), .vpp_high_q(vpp_high_q),
      .vcc_prog_q(vcc_prog_q), .vcc_fast_q(vcc_fast_q));
   otpc_rom_model mdl (.addr(rom_addr_q), .din(bus), .cs_n(chip_sel_n_q),
      .oe_n(out_en_n_q), .program_strobe_n(program_strobe_n_q),
      .vpp(vpp_high_q), .vcc_prog(vcc_prog_q), .extra(extra),
      .dout(mdl_out));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // One request, held for a single taking edge, then a bounded wait.
   task automatic op(input logic p);
      int n;
      n = 0;
      req_prog = p;
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      chk(8'(busy_q), 8'h01);
      while (done_q !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      chk(8'(n < 5000), 8'h01);
      chk(8'(busy_q), 8'h00);
      @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         $display("ERROR %0t run too long", $time);
         test_done;
      end
   end
   initial begin
      seed = 32'h3c5e;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (i = 0; i < 10; i++) begin
         req_addr = (i >= 7) ? 13'(used[i - 7]) : 13'($random(seed));
         req_data = (i == 9) ? 8'hff : 8'($random(seed));
         req_fast = i[0];
         extra = 3'($unsigned($random(seed)) % 3);
         exp_b = ref_mem.exists(req_addr) ? 8'(ref_mem[req_addr]) : 8'hff;
         op(1'b0);
         chk(rdata_q, exp_b);
         exp_b = exp_b & req_data;
         ref_mem[req_addr] = exp_b;
         used.push_back(req_addr);
         op(1'b1);
         chk(rdata_q, exp_b);
         chk(8'(fail_q), 8'(exp_b != req_data));
         if (exp_b == req_data)
            chk(8'(tries_q), 8'(extra) + 8'h02);
         $display("test %0d done", i);
      end
      test_done;
   end
endmodule
`default_nettype wire
